// ### hw/pcbcr_top.sv
// Contract
// - io space enable gates primary io
// - memory space enable gates primary memory
// - no bus master: no upstream, downstream UR
// - refused non-posted gets UR completion
// - bus master set forwards upstream requests
// - legacy bits 3,4,5,7,9 read zero
// - parity response enable gates parity action
// - system error enable gates error reporting
// - interrupt disable blocks own INTx
// - interrupt disable never blocks forwarded INTx
// - signaled system error set on sent message
// - data parity flag never set unless enabled
`timescale 1ns/1ps
`default_nettype none
module pcbcr_top
   import pcbcr_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic                    cfg_wr,
   input  wire logic                    cfg_rd,
   input  wire logic [PCBCR_ADDR_W-1:0] cfg_addr,
   input  wire logic [3:0]              cfg_be,
   input  wire logic [PCBCR_DATA_W-1:0] cfg_wdata,
   output logic      [PCBCR_DATA_W-1:0] cfg_rdata_q,
   output logic                         cfg_rvalid_q,
   input  wire logic                    pri_valid,
   input  wire logic                    pri_is_io,
   input  wire logic                    pri_is_mem,
   output logic                         pri_claim_q,
   output logic                         pri_ignore_q,
   input  wire logic                    dn_valid,
   input  wire logic                    dn_is_io,
   input  wire logic                    dn_is_mem,
   input  wire logic                    dn_np,
   output logic                         up_fwd_q,
   output logic                         dn_ur_q,
   output logic                         dn_ur_cpl_q,
   input  wire logic                    fatal_det,
   input  wire logic                    nonfatal_det,
   output logic                         system_error_report_fatal_q,
   output logic                         system_error_report_nonfatal_q,
   input  wire logic                    parity_det,
   output logic                         parity_act_q,
   input  wire logic                    own_int,
   input  wire logic                    dn_intx,
   output logic                         intx_q,
   output logic                         intx_fwd_q
);

   // ***************************************************************
   // configuration access decode
   // ***************************************************************
   logic [15:0] cmd_q;
   logic [15:0] cmd_d;
   logic        hit;
   logic        wr_hit;
   logic        sse_q;
   logic        mdpe_q;
   logic        sse_clr;
   logic        mdpe_clr;
   logic [31:0] rd_word;

   // dword match at the command/status offset
   assign hit    = cfg_addr[PCBCR_ADDR_W-1:2] == PCBCR_CMD_OFFSET[PCBCR_ADDR_W-1:2];
   assign wr_hit = cfg_wr & hit;

   // rw1c clears on the status high byte lane
   assign sse_clr  = wr_hit & cfg_be[PCBCR_LANE_STS_HI] & cfg_wdata[PCBCR_SSE_BIT];
   assign mdpe_clr = wr_hit & cfg_be[PCBCR_LANE_STS_HI] & cfg_wdata[PCBCR_MDPE_BIT];

   // ***************************************************************
   // command register
   // ***************************************************************

   // byte-enabled merge through the writable mask
   always_comb begin
      cmd_d = cmd_q;
      if (wr_hit && cfg_be[PCBCR_LANE_CMD_LO]) begin
         cmd_d[7:0] = pcbcr_merge(cmd_q[7:0], cfg_wdata[7:0],
                                  PCBCR_CMD_WR_MASK[7:0]);
      end
      if (wr_hit && cfg_be[PCBCR_LANE_CMD_HI]) begin
         cmd_d[15:8] = pcbcr_merge(cmd_q[15:8], cfg_wdata[15:8],
                                   PCBCR_CMD_WR_MASK[15:8]);
      end
   end

   // command storage, cleared at reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cmd_q <= PCBCR_CMD_RESET;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   // ***************************************************************
   // read path
   // ***************************************************************

   // status half: capability list, parity, system error
   always_comb begin
      rd_word                     = 32'h0000_0000;
      rd_word[15:0]               = cmd_q & PCBCR_CMD_WR_MASK;
      rd_word[PCBCR_CAP_LIST_BIT] = 1'b1;
      rd_word[PCBCR_MDPE_BIT]     = mdpe_q;
      rd_word[PCBCR_SSE_BIT]      = sse_q;
   end

   // registered read answer, unmapped offsets read zero
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cfg_rdata_q  <= 32'h0000_0000;
         cfg_rvalid_q <= 1'b0;
      end else begin
         cfg_rvalid_q <= cfg_rd;
         if (cfg_rd) begin
            cfg_rdata_q <= hit ? rd_word : 32'h0000_0000;
         end
      end
   end

   // ***************************************************************
   // request gating
   // ***************************************************************
   pcbcr_req_gate u_req (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .io_en        (cmd_q[PCBCR_IO_EN_BIT]),
      .mem_en       (cmd_q[PCBCR_MEM_EN_BIT]),
      .bm_en        (cmd_q[PCBCR_BM_EN_BIT]),
      .pri_valid    (pri_valid),
      .pri_is_io    (pri_is_io),
      .pri_is_mem   (pri_is_mem),
      .dn_valid     (dn_valid),
      .dn_is_io     (dn_is_io),
      .dn_is_mem    (dn_is_mem),
      .dn_np        (dn_np),
      .pri_claim_q  (pri_claim_q),
      .pri_ignore_q (pri_ignore_q),
      .up_fwd_q     (up_fwd_q),
      .dn_ur_q      (dn_ur_q),
      .dn_ur_cpl_q  (dn_ur_cpl_q)
   );

   // ***************************************************************
   // error, parity and interrupt gating
   // ***************************************************************
   pcbcr_err_gate u_err (
      .ref_clk        (ref_clk),
      .rst_n          (rst_n),
      .system_error_report_en        (cmd_q[PCBCR_SYSTEM_ERROR_REPORT_EN_BIT]),
      .perr_en        (cmd_q[PCBCR_PERR_EN_BIT]),
      .int_dis        (cmd_q[PCBCR_INT_DIS_BIT]),
      .fatal_det      (fatal_det),
      .nonfatal_det   (nonfatal_det),
      .parity_det     (parity_det),
      .own_int        (own_int),
      .dn_intx        (dn_intx),
      .sse_clr        (sse_clr),
      .mdpe_clr       (mdpe_clr),
      .fatal_msg_q    (system_error_report_fatal_q),
      .nonfatal_msg_q (system_error_report_nonfatal_q),
      .parity_act_q   (parity_act_q),
      .sse_q          (sse_q),
      .mdpe_q         (mdpe_q),
      .intx_q         (intx_q),
      .intx_fwd_q     (intx_fwd_q)
   );

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // primary io claimed exactly when enabled
   property p_io_gate;
      pri_valid && pri_is_io && !pri_is_mem
         |=> (pri_claim_q == $past(cmd_q[PCBCR_IO_EN_BIT])) && (pri_ignore_q != pri_claim_q);
   endproperty
   a_io_gate: assert property (p_io_gate) else $error("io decode gate wrong");

   // primary memory claimed exactly when enabled
   property p_mem_gate;
      pri_valid && pri_is_mem && !pri_is_io
         |=> pri_claim_q == $past(cmd_q[PCBCR_MEM_EN_BIT]);
   endproperty
   a_mem_gate: assert property (p_mem_gate) else $error("memory decode gate wrong");

   // without bus master nothing goes upstream, UR instead
   property p_no_master;
      dn_valid && (dn_is_io || dn_is_mem) && !cmd_q[PCBCR_BM_EN_BIT]
         |=> !up_fwd_q && dn_ur_q;
   endproperty
   a_no_master: assert property (p_no_master) else $error("upstream without master");

   // refused non-posted answered by UR completion
   property p_ur_cpl;
      dn_valid && dn_is_mem && dn_np && !cmd_q[PCBCR_BM_EN_BIT] |=> dn_ur_cpl_q;
   endproperty
   a_ur_cpl: assert property (p_ur_cpl) else $error("missing ur completion");

   // bus master forwards upstream
   property p_forward;
      dn_valid && dn_is_io && cmd_q[PCBCR_BM_EN_BIT] |=> up_fwd_q && !dn_ur_q;
   endproperty
   a_forward: assert property (p_forward) else $error("request not forwarded");

   // full write then read shows only the writable bits
   sequence s_write_all;
      wr_hit && (cfg_be[1:0] == 2'b11) && (cfg_wdata[15:0] == 16'hffff) && !cfg_rd;
   endsequence
   sequence s_read_cmd;
      cfg_rd && hit && !cfg_wr;
   endsequence
   sequence s_no_write;
      !cfg_wr;
   endsequence
   property p_ro_zero;
      s_write_all ##1 s_no_write ##1 s_read_cmd |=> cfg_rdata_q[15:0] == PCBCR_CMD_WR_MASK;
   endproperty
   a_ro_zero: assert property (p_ro_zero) else $error("read-only bits not zero");

   // reserved bits never stored
   property p_reserved;
      cmd_q[15:11] == 5'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits stored");

   // parity action only when response enabled
   property p_parity;
      parity_det |=> parity_act_q == $past(cmd_q[PCBCR_PERR_EN_BIT]);
   endproperty
   a_parity: assert property (p_parity) else $error("parity action gate wrong");

   // fatal error messages gated by system error enable
   property p_system_error_report_gate;
      fatal_det && !cmd_q[PCBCR_SYSTEM_ERROR_REPORT_EN_BIT] |=> !system_error_report_fatal_q;
   endproperty
   a_system_error_report_gate: assert property (p_system_error_report_gate) else $error("reported while disabled");

   // sent nonfatal message raises its output and the signaled flag
   sequence s_msg_sent;
      nonfatal_det && cmd_q[PCBCR_SYSTEM_ERROR_REPORT_EN_BIT];
   endsequence
   property p_sse_set;
      s_msg_sent |=> system_error_report_nonfatal_q && sse_q;
   endproperty
   a_sse_set: assert property (p_sse_set) else $error("signaled flag not set");

   // parity flag rises only with the enable
   property p_mdpe;
      $rose(mdpe_q) |-> $past(cmd_q[PCBCR_PERR_EN_BIT]) && $past(parity_det);
   endproperty
   a_mdpe: assert property (p_mdpe) else $error("parity flag set while disabled");

   // own interrupt blocked by disable
   property p_int_dis;
      own_int && cmd_q[PCBCR_INT_DIS_BIT] |=> !intx_q;
   endproperty
   a_int_dis: assert property (p_int_dis) else $error("own intx while disabled");

   // forwarded interrupts follow regardless of disable
   property p_int_fwd;
      cmd_q[PCBCR_INT_DIS_BIT] |=> intx_fwd_q == $past(dn_intx);
   endproperty
   a_int_fwd: assert property (p_int_fwd) else $error("forwarded intx blocked");

   // nonfatal messages gated by system error enable
   property p_system_error_report_nf;
      nonfatal_det && !cmd_q[PCBCR_SYSTEM_ERROR_REPORT_EN_BIT] |=> !system_error_report_nonfatal_q;
   endproperty
   a_system_error_report_nf: assert property (p_system_error_report_nf) else $error("nonfatal sent while disabled");

   // a sent fatal message raises the signaled flag
   property p_fatal_sse;
      fatal_det && cmd_q[PCBCR_SYSTEM_ERROR_REPORT_EN_BIT] |=> system_error_report_fatal_q && sse_q;
   endproperty
   a_fatal_sse: assert property (p_fatal_sse) else $error("fatal left flag clear");

   // signaled flag rises only after a sent message
   property p_sse_src;
      $rose(sse_q) |-> $past(cmd_q[PCBCR_SYSTEM_ERROR_REPORT_EN_BIT])
                       && ($past(fatal_det) || $past(nonfatal_det));
   endproperty
   a_sse_src: assert property (p_sse_src) else $error("flag set without message");

   // set and clear in one cycle leave the flag set
   property p_sse_wins;
      nonfatal_det && cmd_q[PCBCR_SYSTEM_ERROR_REPORT_EN_BIT] && sse_clr |=> sse_q;
   endproperty
   a_sse_wins: assert property (p_sse_wins) else $error("clear beat set");

   // own interrupt passes while not disabled
   property p_int_own;
      own_int && !cmd_q[PCBCR_INT_DIS_BIT] |=> intx_q;
   endproperty
   a_int_own: assert property (p_int_own) else $error("own intx lost while enabled");

   // posted downstream requests never get a completion
   property p_posted;
      dn_valid && !dn_np |=> !dn_ur_cpl_q;
   endproperty
   a_posted: assert property (p_posted) else $error("completion for posted request");

   // enabled parity error raises the data parity flag
   property p_mdpe_set;
      parity_det && cmd_q[PCBCR_PERR_EN_BIT] |=> mdpe_q;
   endproperty
   a_mdpe_set: assert property (p_mdpe_set) else $error("parity flag not set");

endmodule
`default_nettype wire

// ### hw/pcbcr_pkg.sv
package pcbcr_pkg;

   // ***************************************************************
   // configuration space placement
   // ***************************************************************
   localparam logic [11:0] PCBCR_CMD_OFFSET  = 12'h004;
   localparam int          PCBCR_ADDR_W      = 12;
   localparam int          PCBCR_DATA_W      = 32;

   // ***************************************************************
   // command half field positions
   // ***************************************************************
   localparam int PCBCR_IO_EN_BIT     = 0;
   localparam int PCBCR_MEM_EN_BIT    = 1;
   localparam int PCBCR_BM_EN_BIT     = 2;
   localparam int PCBCR_PERR_EN_BIT   = 6;
   localparam int PCBCR_SYSTEM_ERROR_REPORT_EN_BIT   = 8;
   localparam int PCBCR_INT_DIS_BIT   = 10;

   // writable bits: 0,1,2,6,8,10; all others read zero
   localparam logic [15:0] PCBCR_CMD_WR_MASK = 16'h0547;
   localparam logic [15:0] PCBCR_CMD_RESET   = 16'h0000;

   // ***************************************************************
   // status half field positions (dword bit numbers)
   // ***************************************************************
   localparam int PCBCR_CAP_LIST_BIT  = 20;
   localparam int PCBCR_MDPE_BIT      = 24;
   localparam int PCBCR_SSE_BIT       = 30;

   // ***************************************************************
   // byte lanes
   // ***************************************************************
   localparam int PCBCR_LANE_CMD_LO   = 0;
   localparam int PCBCR_LANE_CMD_HI   = 1;
   localparam int PCBCR_LANE_STS_HI   = 3;

   // merge one written byte into a byte under a writable mask
   function automatic logic [7:0] pcbcr_merge(
      input logic [7:0] old_v,
      input logic [7:0] new_v,
      input logic [7:0] mask
   );
      pcbcr_merge = (old_v & ~mask) | (new_v & mask);
   endfunction

endpackage

// ### hw/pcbcr_req_gate.sv
`timescale 1ns/1ps
`default_nettype none
module pcbcr_req_gate
   import pcbcr_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic io_en,
   input  wire logic mem_en,
   input  wire logic bm_en,
   input  wire logic pri_valid,
   input  wire logic pri_is_io,
   input  wire logic pri_is_mem,
   input  wire logic dn_valid,
   input  wire logic dn_is_io,
   input  wire logic dn_is_mem,
   input  wire logic dn_np,
   output logic      pri_claim_q,
   output logic      pri_ignore_q,
   output logic      up_fwd_q,
   output logic      dn_ur_q,
   output logic      dn_ur_cpl_q
);

   logic pri_hit;
   logic dn_hit;

   // primary io/memory decode gated by the space enables
   assign pri_hit = (pri_is_io & io_en) | (pri_is_mem & mem_en);
   assign dn_hit  = dn_valid & (dn_is_io | dn_is_mem);

   // primary side claim or ignore
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pri_claim_q  <= 1'b0;
         pri_ignore_q <= 1'b0;
      end else begin
         pri_claim_q  <= pri_valid & pri_hit;
         pri_ignore_q <= pri_valid & ~pri_hit;
      end
   end

   // upstream forwarding or unsupported request
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         up_fwd_q    <= 1'b0;
         dn_ur_q     <= 1'b0;
         dn_ur_cpl_q <= 1'b0;
      end else begin
         up_fwd_q    <= dn_hit & bm_en;
         dn_ur_q     <= dn_hit & ~bm_en;
         dn_ur_cpl_q <= dn_hit & ~bm_en & dn_np;
      end
   end

endmodule
`default_nettype wire

// ### hw/pcbcr_err_gate.sv
`timescale 1ns/1ps
`default_nettype none
module pcbcr_err_gate
   import pcbcr_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic system_error_report_en,
   input  wire logic perr_en,
   input  wire logic int_dis,
   input  wire logic fatal_det,
   input  wire logic nonfatal_det,
   input  wire logic parity_det,
   input  wire logic own_int,
   input  wire logic dn_intx,
   input  wire logic sse_clr,
   input  wire logic mdpe_clr,
   output logic      fatal_msg_q,
   output logic      nonfatal_msg_q,
   output logic      parity_act_q,
   output logic      sse_q,
   output logic      mdpe_q,
   output logic      intx_q,
   output logic      intx_fwd_q
);

   logic msg_send;
   logic par_take;

   assign msg_send = system_error_report_en & (fatal_det | nonfatal_det);
   assign par_take = perr_en & parity_det;

   // error messages and parity action
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fatal_msg_q    <= 1'b0;
         nonfatal_msg_q <= 1'b0;
         parity_act_q   <= 1'b0;
      end else begin
         fatal_msg_q    <= system_error_report_en & fatal_det;
         nonfatal_msg_q <= system_error_report_en & nonfatal_det;
         parity_act_q   <= par_take;
      end
   end

   // sticky status flags, set wins over clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sse_q  <= 1'b0;
         mdpe_q <= 1'b0;
      end else begin
         sse_q  <= msg_send | (sse_q & ~sse_clr);
         mdpe_q <= par_take | (mdpe_q & ~mdpe_clr);
      end
   end

   // own interrupt gated, downstream interrupts pass
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         intx_q     <= 1'b0;
         intx_fwd_q <= 1'b0;
      end else begin
         intx_q     <= own_int & ~int_dis;
         intx_fwd_q <= dn_intx;
      end
   end

endmodule
`default_nettype wire

// ### tb/pcbcr_rc_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcbcr_rc_model
   import pcbcr_pkg::*;
(
   input  wire logic                    ref_clk,
   output logic                         cfg_wr,
   output logic                         cfg_rd,
   output logic      [PCBCR_ADDR_W-1:0] cfg_addr,
   output logic      [3:0]              cfg_be,
   output logic      [PCBCR_DATA_W-1:0] cfg_wdata,
   input  wire logic [PCBCR_DATA_W-1:0] cfg_rdata_q,
   input  wire logic                    cfg_rvalid_q
);
   // ***************************************************************
   // configuration requester
   // ***************************************************************
   // idle bus at time zero
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 12'h5a5;
      cfg_be = 4'h0;
      cfg_wdata = 32'ha5a5a5a5;
   end

   // released lines show the inverse so stale values never match
   task automatic park();
      cfg_addr = ~cfg_addr;
      cfg_wdata = ~cfg_wdata;
      cfg_be = ~cfg_be;
   endtask

   // one write strobe, held across exactly one rising edge
   task automatic cfg_write(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge ref_clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(negedge ref_clk);
      cfg_wr = 1'b0;
      park();
   endtask

   // one read strobe; the answer is flagged valid in the following cycle only, the data holds until the next read
   task automatic cfg_read(input logic [11:0] a, output logic [31:0] d, output logic ok);
      @(negedge ref_clk);
      cfg_rd = 1'b1;
      cfg_addr = a;
      cfg_be = 4'hf;
      @(negedge ref_clk);
      cfg_rd = 1'b0;
      ok = cfg_rvalid_q;
      d = cfg_rdata_q;
      park();
   endtask
endmodule
`default_nettype wire

// ### tb/pcie_bridge_command_register_test.sv
`timescale 1ns/1ps
`default_nettype none
module pcie_bridge_command_register_test;
   import pcbcr_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [9:0]  stim = '0;
   logic        own_int = 1'b0;
   logic        dn_intx = 1'b0;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cycles = 0;
   wire logic        cfg_wr, cfg_rd, cfg_rvalid_q;
   wire logic [11:0] cfg_addr;
   wire logic [3:0]  cfg_be;
   wire logic [31:0] cfg_wdata, cfg_rdata_q;
   wire logic        pri_valid, pri_is_io, pri_is_mem, pri_claim_q, pri_ignore_q;
   wire logic        dn_valid, dn_is_io, dn_is_mem, dn_np, up_fwd_q, dn_ur_q, dn_ur_cpl_q;
   wire logic        fatal_det, nonfatal_det, parity_det, parity_act_q;
   wire logic        system_error_report_fatal_q, system_error_report_nonfatal_q;
   wire logic        intx_q, intx_fwd_q;
   wire logic [7:0]  obs;

   // ***************************************************************
   // clock, request packing, instances
   // ***************************************************************
   // 100 ns period
   always #50 ref_clk = ~ref_clk;

   // one vector for all single-cycle requests, one for all pulse answers
   assign {pri_valid, pri_is_io, pri_is_mem, dn_valid, dn_is_io, dn_is_mem, dn_np,
           fatal_det, nonfatal_det, parity_det} = stim;
   assign obs = {pri_claim_q, pri_ignore_q, up_fwd_q, dn_ur_q, dn_ur_cpl_q,
                 system_error_report_fatal_q, system_error_report_nonfatal_q, parity_act_q};

   pcbcr_rc_model u_rc (.ref_clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
                        .cfg_rdata_q, .cfg_rvalid_q);
   pcbcr_top uut (.ref_clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
                  .cfg_rdata_q, .cfg_rvalid_q, .pri_valid, .pri_is_io, .pri_is_mem,
                  .pri_claim_q, .pri_ignore_q, .dn_valid, .dn_is_io, .dn_is_mem, .dn_np,
                  .up_fwd_q, .dn_ur_q, .dn_ur_cpl_q, .fatal_det, .nonfatal_det,
                  .system_error_report_fatal_q, .system_error_report_nonfatal_q,
                  .parity_det, .parity_act_q, .own_int, .dn_intx, .intx_q, .intx_fwd_q);

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic final_report();
      if (bad_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // read through the requester and compare with the expected dword
   task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic        ok;
      u_rc.cfg_read(a, d, ok);
      check({what, " valid"}, {31'h0, ok}, 32'h1);
      check(what, d, exp);
   endtask

   // offer one request for one cycle, return the answers of the next cycle
   task automatic step(input logic [9:0] s, output logic [31:0] o);
      @(negedge ref_clk);
      stim = s;
      @(negedge ref_clk);
      stim = '0;
      o = {24'h0, obs};
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset();
      check("idle answers", {24'h0, obs}, 32'h0);
      rd_check(12'h004, 32'h00100000, "reset dword");
   endtask

   // hardwired and reserved bits, lane handling, unmapped place
   task automatic t_bits();
      u_rc.cfg_write(12'h004, 4'hf, 32'hffffffff);
      rd_check(12'h004, 32'h00100547, "all ones");
      u_rc.cfg_write(12'h007, 4'h2, 32'h00000000);
      rd_check(12'h004, 32'h00100047, "high lane cleared");
      u_rc.cfg_write(12'h004, 4'h1, 32'h000000b8);
      rd_check(12'h004, 32'h00100000, "legacy low bits");
      u_rc.cfg_write(12'h004, 4'h2, 32'h0000fa00);
      rd_check(12'h004, 32'h00100000, "legacy high bits");
      u_rc.cfg_write(12'h008, 4'hf, 32'hffffffff);
      rd_check(12'h008, 32'h00000000, "unmapped read");
      rd_check(12'h004, 32'h00100000, "unmapped write");
   endtask

   // every combination of the three enables against primary io, primary memory, downstream memory non-posted and downstream io posted requests
   task automatic t_gates();
      logic [31:0] o;
      logic [2:0]  c;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         u_rc.cfg_write(12'h004, 4'h1, {29'h0, c});
         rd_check(12'h004, {29'h0020000, c}, "enables");
         step(10'b1100000000, o);
         check("primary io", o, {24'h0, c[0], ~c[0], 6'h0});
         step(10'b1010000000, o);
         check("primary mem", o, {24'h0, c[1], ~c[1], 6'h0});
         step(10'b0001011000, o);
         check("down mem np", o, {26'h0, c[2], ~c[2], ~c[2], 3'h0});
         step(10'b0001100000, o);
         check("down io posted", o, {26'h0, c[2], ~c[2], 4'h0});
      end
   endtask

   // error reporting and parity action, with the status flags they set
   task automatic t_errors();
      logic [31:0] o;
      logic        e;
      logic [15:0] cmd;
      for (int i = 0; i < 2; i++) begin
         e = i[0];
         cmd = e ? 16'h0140 : 16'h0000;
         u_rc.cfg_write(12'h004, 4'h3, {16'h0, cmd});
         step(10'b0000000100, o);
         check("fatal report", o, {29'h0, e, 2'h0});
         step(10'b0000000010, o);
         check("nonfatal report", o, {30'h0, e, 1'b0});
         step(10'b0000000001, o);
         check("parity action", o, {31'h0, e});
         rd_check(12'h004, {1'b0, e, 5'h0, e, 8'h10, cmd}, "error flags");
         u_rc.cfg_write(12'h004, 4'h8, 32'h41000000);
         rd_check(12'h004, {16'h0010, cmd}, "flags cleared");
         // message and flag clear in the same cycle: the set wins
         fork
            u_rc.cfg_write(12'h004, 4'h8, 32'h40000000);
            step(10'b0000000010, o);
         join
         check("nonfatal with clear", o, {30'h0, e, 1'b0});
         rd_check(12'h004, {1'b0, e, 14'h0010, cmd}, "set beats clear");
      end
   endtask

   // own interrupt gated, forwarded interrupt untouched; then a reset
   task automatic t_intx();
      logic e;
      own_int = 1'b1;
      dn_intx = 1'b1;
      for (int i = 0; i < 2; i++) begin
         e = i[0];
         u_rc.cfg_write(12'h004, 4'h2, {21'h0, e, 10'h0});
         repeat (2) @(negedge ref_clk);
         check("own intx", {31'h0, intx_q}, {31'h0, ~e});
         check("forwarded intx", {31'h0, intx_fwd_q}, 32'h1);
      end
      own_int = 1'b0;
      dn_intx = 1'b0;
      repeat (2) @(negedge ref_clk);
      check("intx released", {30'h0, intx_q, intx_fwd_q}, 32'h0);
      rst_n = 1'b0;
      @(negedge ref_clk);
      rst_n = 1'b1;
      rd_check(12'h004, 32'h00100000, "second reset");
   endtask

   // ***************************************************************
   // run control
   // ***************************************************************
   // cut a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         final_report();
      end
   end

   // main sequence
   initial begin
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      t_reset();
      t_bits();
      t_gates();
      t_errors();
      t_intx();
      final_report();
   end
endmodule
`default_nettype wire
